/* File: spp_pkg.sv */
// shared constants and types for the serial programming port link
package spp_pkg;

  // ----------------------------------------------------------------
  // frame and timing
  // ----------------------------------------------------------------
  localparam logic [3:0] RX_LAST_BIT  = 4'h9;
  localparam logic [3:0] RX_DATA_BITS = 4'h8;
  localparam logic [3:0] TX_FRAME_BITS = 4'hc;
  localparam logic [8:0] IDLE_MIN_BITS = 9'h002;
  localparam logic [7:0] GUARD_RST     = 8'h80;
  localparam logic [3:0] KEY_BYTES     = 4'h8;
  localparam logic [3:0] ONE_OPERAND   = 4'h1;

  // ----------------------------------------------------------------
  // control/status space map
  // ----------------------------------------------------------------
  localparam logic [3:0] CSS_GUARD_ADDR = 4'h2;

  // ----------------------------------------------------------------
  // instruction encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_LD_IND     = 8'h20;
  localparam logic [7:0] OP_ST_IND     = 8'h60;
  localparam logic [7:0] OP_IND_MASK   = 8'hfb;
  localparam logic [7:0] OP_PTR_ST     = 8'h68;
  localparam logic [7:0] OP_PTR_MASK   = 8'hfe;
  localparam logic [7:0] OP_IO_MASK    = 8'h90;
  localparam logic [7:0] OP_LD_IO      = 8'h10;
  localparam logic [7:0] OP_ST_IO      = 8'h90;
  localparam logic [7:0] OP_CSS_MASK   = 8'hf0;
  localparam logic [7:0] OP_LD_CSS     = 8'h80;
  localparam logic [7:0] OP_ST_CSS     = 8'hc0;
  localparam logic [7:0] OP_KEY        = 8'he0;
  localparam int         OP_INC_BIT    = 2;

  typedef enum logic [3:0] {
    K_LD_DS, K_ST_DS, K_ST_PTR, K_LD_IO, K_ST_IO,
    K_LD_CSS, K_ST_CSS, K_KEY, K_BAD
  } spp_kind_t;

  typedef enum {
    MS_INSTR, MS_OPERAND, MS_ISSUE, MS_WAIT_RSP, MS_SEND, MS_ERROR
  } spp_msg_state_t;

  // access request toward data or i/o space
  typedef struct packed {
    logic        write;
    logic        io;
    logic [15:0] addr;
    logic [7:0]  data;
  } spp_req_t;

endpackage

/* File: spp_link.sv */
// device side of the serial programming port: link phy and message layer
// Functional notes
// - after a start bit, sample each bit on rising link clock through stop two
// - a completed good frame hands its byte to the message layer
// - a stop bit sampled low raises a frame error
// - parity accumulated over data bits; mismatch with parity bit raises error
// - a complete frame of all zeros raises break detection
// - any receive exception puts the message layer in error, phy in receive
// - transmit loads the shift register then shifts one frame at link rate
// - zeros always driven; ones driven first cycle only, then released
// - while released in transmit, a low line is a collision
// - collision stops transmit, drops driver, returns to receive, enters error
// - both stop bits always sent high
// - guard time plus two idle bits precede start after receive
// - guard time is a control space setting, 128 bits after reset
// - read instructions are answered by the device sending the operand
// - one operand per instruction, eight after the key instruction
// - control space by its load/store; data space via pointer, i/o space direct
// - exception aborts, holds error until a break, then default state
// - frame: low start, eight data lsb first, parity, two high stops
// - parity is exclusive-or of the eight data bits
// - break is low for at least twelve bit times, maybe longer
// - data changes on falling edges, sampled on rising; receive by default
`timescale 1ns/100ps

module spp_link
  import spp_pkg::*;
(
  input  wire logic     core_clk,
  input  wire logic     resetn,
  input  wire logic     prog_link_clock_pin,
  input  wire logic     prog_link_data_pin_in,
  output logic          prog_link_data_pin_out,
  output logic          prog_link_data_pin_oe,
  output logic          req_valid,
  output spp_req_t      req,
  input  wire logic     req_ready,
  input  wire logic     rsp_valid,
  input  wire logic [7:0] rsp_data,
  output logic          key_valid,
  output logic [63:0]   key_value
);

  // ----------------------------------------------------------------
  // pin synchronisers and link clock edges
  // ----------------------------------------------------------------
  logic clk_s1_reg, clk_s2_reg, clk_s3_reg;
  logic dat_s1_reg, dat_s2_reg;
  logic rise, fall;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      // link clock idles high: no false edge once reset lifts
      clk_s1_reg <= 1'b1;
      clk_s2_reg <= 1'b1;
      clk_s3_reg <= 1'b1;
      dat_s1_reg <= 1'b1;
      dat_s2_reg <= 1'b1;
    end
    else
    begin
      clk_s1_reg <= prog_link_clock_pin;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
      dat_s1_reg <= prog_link_data_pin_in;
      dat_s2_reg <= dat_s1_reg;
    end
  end

  assign rise = clk_s2_reg & ~clk_s3_reg;
  assign fall = ~clk_s2_reg & clk_s3_reg;

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  logic        tx_active_reg;
  logic        rx_busy_reg, rx_armed_reg, rx_par_reg;
  logic [3:0]  rx_cnt_reg;
  logic [10:0] rx_sr_reg;
  logic [10:0] rx_frame;
  logic        rx_ok_reg, rx_exc_reg, rx_brk_reg;
  logic [7:0]  rx_byte_reg;

  assign rx_frame = {dat_s2_reg, rx_sr_reg[10:1]};

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_busy_reg  <= 1'b0;
      rx_armed_reg <= 1'b0;
      rx_par_reg   <= 1'b0;
      rx_cnt_reg   <= 4'h0;
      rx_sr_reg    <= 11'h000;
      rx_ok_reg    <= 1'b0;
      rx_exc_reg   <= 1'b0;
      rx_brk_reg   <= 1'b0;
      rx_byte_reg  <= 8'h00;
    end
    else
    begin
      rx_ok_reg  <= 1'b0;
      rx_exc_reg <= 1'b0;
      rx_brk_reg <= 1'b0;
      if (tx_active_reg)
      begin
        rx_busy_reg  <= 1'b0;
        rx_armed_reg <= 1'b0;
      end
      else if (rise && !rx_busy_reg)
      begin
        rx_armed_reg <= dat_s2_reg;
        if (rx_armed_reg && !dat_s2_reg)
        begin
          rx_busy_reg <= 1'b1;
          rx_cnt_reg  <= 4'h0;
          rx_par_reg  <= 1'b0;
        end
      end
      else if (rise)
      begin
        rx_sr_reg  <= rx_frame;
        rx_cnt_reg <= rx_cnt_reg + 4'h1;
        if (rx_cnt_reg < RX_DATA_BITS)
          rx_par_reg <= rx_par_reg ^ dat_s2_reg;
        if (rx_cnt_reg == RX_LAST_BIT + 4'h1)
        begin
          rx_busy_reg  <= 1'b0;
          rx_armed_reg <= dat_s2_reg;
          if (rx_frame == 11'h000)
            rx_brk_reg <= 1'b1;
          else if (!rx_frame[9] || !rx_frame[10])
            rx_exc_reg <= 1'b1;
          else if (rx_par_reg != rx_frame[8])
            rx_exc_reg <= 1'b1;
          else
          begin
            rx_ok_reg   <= 1'b1;
            rx_byte_reg <= rx_frame[7:0];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // transmitter with released-high driver and collision check
  // ----------------------------------------------------------------
  logic        tx_go_reg;
  logic [7:0]  tx_byte_reg;
  logic [7:0]  guard_reg;
  logic [8:0]  tx_idle_reg;
  logic [3:0]  tx_left_reg;
  logic [11:0] tx_sr_reg;
  logic        tx_prev_reg, tx_bit;
  logic        coll_reg, tx_done_reg;

  assign tx_bit = (tx_idle_reg != 9'h000) ? 1'b1 : tx_sr_reg[0];

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_active_reg          <= 1'b0;
      tx_idle_reg            <= 9'h000;
      tx_left_reg            <= 4'h0;
      tx_sr_reg              <= 12'hfff;
      tx_prev_reg            <= 1'b0;
      coll_reg               <= 1'b0;
      tx_done_reg            <= 1'b0;
      prog_link_data_pin_out <= 1'b1;
      prog_link_data_pin_oe  <= 1'b0;
    end
    else
    begin
      coll_reg    <= 1'b0;
      tx_done_reg <= 1'b0;
      if (tx_go_reg)
      begin
        tx_active_reg <= 1'b1;
        tx_idle_reg   <= {1'b0, guard_reg} + IDLE_MIN_BITS;
        tx_left_reg   <= TX_FRAME_BITS;
        tx_sr_reg     <= {2'b11, ^tx_byte_reg, tx_byte_reg, 1'b0};
        tx_prev_reg   <= 1'b0;
      end
      else if (tx_active_reg && rise && !prog_link_data_pin_oe
               && !dat_s2_reg)
      begin
        coll_reg              <= 1'b1;
        tx_active_reg         <= 1'b0;
        prog_link_data_pin_oe <= 1'b0;
      end
      else if (tx_active_reg && fall)
      begin
        if (tx_idle_reg == 9'h000 && tx_left_reg == 4'h0)
        begin
          tx_active_reg          <= 1'b0;
          tx_done_reg            <= 1'b1;
          prog_link_data_pin_out <= 1'b1;
          prog_link_data_pin_oe  <= 1'b0;
        end
        else
        begin
          if (tx_idle_reg != 9'h000)
            tx_idle_reg <= tx_idle_reg - 9'h001;
          else
          begin
            tx_sr_reg   <= {1'b1, tx_sr_reg[11:1]};
            tx_left_reg <= tx_left_reg - 4'h1;
          end
          tx_prev_reg            <= tx_bit;
          prog_link_data_pin_out <= tx_bit;
          prog_link_data_pin_oe  <= !tx_bit || !tx_prev_reg;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // two-entry request buffer toward data or i/o space
  // ----------------------------------------------------------------
  logic     push, buf_in_ready;
  logic     spare_valid_reg;
  spp_req_t spare_reg, msg_req_reg;
  spp_msg_state_t state_reg;

  assign buf_in_ready = !spare_valid_reg;
  assign push = (state_reg == MS_ISSUE) && buf_in_ready;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      req_valid       <= 1'b0;
      req             <= '0;
      spare_valid_reg <= 1'b0;
      spare_reg       <= '0;
    end
    else if (!req_valid || req_ready)
    begin
      req_valid <= spare_valid_reg || push;
      req       <= spare_valid_reg ? spare_reg : msg_req_reg;
      if (spare_valid_reg && push)
        spare_reg <= msg_req_reg;
      else
        spare_valid_reg <= 1'b0;
    end
    else if (push)
    begin
      spare_reg       <= msg_req_reg;
      spare_valid_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // message layer
  // ----------------------------------------------------------------
  spp_kind_t  kind_reg;
  spp_kind_t  kind;
  logic [3:0] opnd_cnt_reg;
  logic [7:0] instr_reg;
  logic [15:0] ptr_reg;
  logic [7:0] op;

  assign op = rx_byte_reg;

  always_comb
  begin
    kind = K_BAD;
    if ((op & OP_IND_MASK) == OP_LD_IND)
      kind = K_LD_DS;
    else if ((op & OP_IND_MASK) == OP_ST_IND)
      kind = K_ST_DS;
    else if ((op & OP_PTR_MASK) == OP_PTR_ST)
      kind = K_ST_PTR;
    else if ((op & OP_IO_MASK) == OP_LD_IO)
      kind = K_LD_IO;
    else if ((op & OP_IO_MASK) == OP_ST_IO)
      kind = K_ST_IO;
    else if ((op & OP_CSS_MASK) == OP_LD_CSS)
      kind = K_LD_CSS;
    else if ((op & OP_CSS_MASK) == OP_ST_CSS)
      kind = K_ST_CSS;
    else if (op == OP_KEY)
      kind = K_KEY;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg    <= MS_INSTR;
      kind_reg     <= K_BAD;
      opnd_cnt_reg <= 4'h0;
      instr_reg    <= 8'h00;
      ptr_reg      <= 16'h0000;
      guard_reg    <= GUARD_RST;
      msg_req_reg  <= '0;
      tx_go_reg    <= 1'b0;
      tx_byte_reg  <= 8'h00;
      key_valid    <= 1'b0;
      key_value    <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      tx_go_reg <= 1'b0;
      key_valid <= 1'b0;
      if (rx_exc_reg || rx_brk_reg || coll_reg)
      begin
        if (state_reg == MS_ERROR && rx_brk_reg)
          state_reg <= MS_INSTR;
        else
          state_reg <= MS_ERROR;
      end
      else
      begin
        unique case (state_reg)
          MS_INSTR:
            if (rx_ok_reg)
            begin
              kind_reg     <= kind;
              instr_reg    <= op;
              opnd_cnt_reg <= (kind == K_KEY) ? KEY_BYTES : ONE_OPERAND;
              msg_req_reg  <= '{write: 1'b0, io: kind == K_LD_IO,
                                addr: (kind == K_LD_IO)
                                  ? {10'h000, op[6:5], op[3:0]} : ptr_reg,
                                data: 8'h00};
              unique case (kind)
                K_LD_DS, K_LD_IO:
                  state_reg <= MS_ISSUE;
                K_LD_CSS:
                begin
                  tx_byte_reg <= (op[3:0] == CSS_GUARD_ADDR)
                                 ? guard_reg : 8'h00;
                  tx_go_reg   <= 1'b1;
                  state_reg   <= MS_SEND;
                end
                K_BAD:
                  state_reg <= MS_ERROR;
                default:
                  state_reg <= MS_OPERAND;
              endcase
            end
          MS_OPERAND:
            if (rx_ok_reg)
            begin
              opnd_cnt_reg <= opnd_cnt_reg - 4'h1;
              state_reg    <= MS_INSTR;
              unique case (kind_reg)
                K_KEY:
                begin
                  key_value <= {op, key_value[63:8]};
                  if (opnd_cnt_reg != ONE_OPERAND)
                    state_reg <= MS_OPERAND;
                  else
                    key_valid <= 1'b1;
                end
                K_ST_PTR:
                  if (instr_reg[0])
                    ptr_reg[15:8] <= op;
                  else
                    ptr_reg[7:0] <= op;
                K_ST_CSS:
                  if (instr_reg[3:0] == CSS_GUARD_ADDR)
                    guard_reg <= op;
                default:
                begin
                  msg_req_reg <= '{write: 1'b1, io: kind_reg == K_ST_IO,
                                   addr: (kind_reg == K_ST_IO)
                                     ? {10'h000, instr_reg[6:5],
                                        instr_reg[3:0]}
                                     : ptr_reg,
                                   data: op};
                  state_reg   <= MS_ISSUE;
                end
              endcase
            end
          MS_ISSUE:
            if (push)
            begin
              if (kind_reg == K_ST_DS && instr_reg[OP_INC_BIT])
                ptr_reg <= ptr_reg + 16'h0001;
              state_reg <= msg_req_reg.write ? MS_INSTR : MS_WAIT_RSP;
            end
          MS_WAIT_RSP:
            if (rsp_valid)
            begin
              if (kind_reg == K_LD_DS && instr_reg[OP_INC_BIT])
                ptr_reg <= ptr_reg + 16'h0001;
              tx_byte_reg <= rsp_data;
              tx_go_reg   <= 1'b1;
              state_reg   <= MS_SEND;
            end
          MS_SEND:
            if (tx_done_reg)
              state_reg <= MS_INSTR;
          MS_ERROR:
            state_reg <= MS_ERROR;
        endcase
      end
    end
  end

endmodule

/* File: spp_link_assertions.sv */
// port-level checks for the serial programming port link
`timescale 1ns/100ps

module spp_link_assertions
  import spp_pkg::*;
(
  input wire logic     core_clk,
  input wire logic     resetn,
  input wire logic     prog_link_clock_pin,
  input wire logic     prog_link_data_pin_out,
  input wire logic     prog_link_data_pin_oe,
  input wire logic     req_valid,
  input wire spp_req_t req,
  input wire logic     req_ready,
  input wire logic     key_valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // length of an actively driven one
  // ----------------------------------------------------------------
  logic [5:0] one_cnt_reg;
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
      one_cnt_reg <= 6'h00;
    else if (prog_link_data_pin_oe && prog_link_data_pin_out)
      one_cnt_reg <= one_cnt_reg + 6'h01;
    else
      one_cnt_reg <= 6'h00;

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_rst_quiet;
    $rose(resetn) |-> !prog_link_data_pin_oe && prog_link_data_pin_out
      && !req_valid && !key_valid;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("link not idle after reset");
  property p_req_hold;
    req_valid && !req_ready |=> req_valid && $stable(req);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("request dropped while stalled");
  property p_key_pulse;
    key_valid |=> !key_valid;
  endproperty
  a_key_pulse: assert property (p_key_pulse)
    else $error("key strobe longer than one cycle");
  property p_zero_driven;
    $fell(prog_link_data_pin_out) |-> prog_link_data_pin_oe;
  endproperty
  a_zero_driven: assert property (p_zero_driven)
    else $error("zero sent without driver");
  property p_one_released;
    one_cnt_reg <= 6'h13;
  endproperty
  a_one_released: assert property (p_one_released)
    else $error("one driven longer than a bit");
  property p_drive_on_fall;
    $rose(prog_link_data_pin_oe) || $fell(prog_link_data_pin_out)
      |-> !prog_link_clock_pin;
  endproperty
  a_drive_on_fall: assert property (p_drive_on_fall)
    else $error("wire changed outside low link clock");
  property p_req_on_rise;
    $rose(req_valid) |-> prog_link_clock_pin;
  endproperty
  a_req_on_rise: assert property (p_req_on_rise)
    else $error("request not tied to a sampled stop bit");
  property p_key_on_rise;
    $rose(key_valid) |-> prog_link_clock_pin;
  endproperty
  a_key_on_rise: assert property (p_key_on_rise)
    else $error("key strobe not tied to a sampled stop bit");
  property p_io_addr;
    req_valid && req.io |-> req.addr[15:6] == 10'h000;
  endproperty
  a_io_addr: assert property (p_io_addr)
    else $error("io address wider than six bits");

  c_write: cover property (req_valid && req_ready && req.write);
  c_key: cover property (key_valid);
  c_tx: cover property ($rose(prog_link_data_pin_oe));
endmodule

bind spp_link spp_link_assertions u_chk (
  .core_clk               (core_clk),
  .resetn                 (resetn),
  .prog_link_clock_pin    (prog_link_clock_pin),
  .prog_link_data_pin_out (prog_link_data_pin_out),
  .prog_link_data_pin_oe  (prog_link_data_pin_oe),
  .req_valid              (req_valid),
  .req                    (req),
  .req_ready              (req_ready),
  .key_valid              (key_valid)
);

/* File: spp_prog_model.sv */
// programmer model: makes the link clock, pulls the shared wire low
`timescale 1ns/100ps

module spp_prog_model (
  output logic      clk_pin,
  output logic      pull_low_n,
  input  wire logic wire_lvl
);
  initial
  begin
    clk_pin    = 1'b1;
    pull_low_n = 1'b1;
  end

  // change after the falling edge, device samples on the rising
  task automatic bit_out(input logic b);
    clk_pin    = 1'b0;
    pull_low_n = b;
    #62.5;
    clk_pin = 1'b1;
    #62.5;
  endtask

  // kind 1 spoils parity, kind 2 drops the second stop bit
  task automatic send(input logic [7:0] d, input logic [1:0] kind);
    logic [11:0] f;
    f = {kind != 2'h2, 1'b1, ^d ^ (kind == 2'h1), d, 1'b0};
    bit_out(1'b1);
    for (int i = 0; i < 12; i++)
      bit_out(f[i]);
  endtask

  task automatic brk;
    bit_out(1'b1);
    for (int i = 0; i < 12; i++)
      bit_out(1'b0);
    bit_out(1'b1);
  endtask

  // collect idle ones then one frame; collide pulls the second idle low
  task automatic recv(input logic collide, output int idle,
                      output logic [11:0] f);
    int n;
    idle = 0;
    n    = 0;
    f    = 12'hfff;
    while (n < 12 && idle < 400)
    begin
      clk_pin    = 1'b0;
      pull_low_n = !(collide && idle == 1 && n == 0);
      #62.5;
      clk_pin = 1'b1;
      if (n > 0 || !wire_lvl)
      begin
        f[n] = wire_lvl;
        n++;
      end
      else
        idle++;
      #62.5;
    end
  endtask
endmodule

/* File: spp_link_test.sv */
// self-checking bench for the serial programming port link
`timescale 1ns/100ps

module spp_link_test;
  import spp_pkg::*;
  logic        core_clk;
  logic        resetn;
  logic        clk_pin;
  logic        pull_low_n;
  logic        data_out;
  logic        data_oe;
  logic        wire_lvl;
  logic        req_valid;
  spp_req_t    req;
  logic        req_ready;
  logic        rsp_valid;
  logic [7:0]  rsp_data;
  logic        key_valid;
  logic [63:0] key_value;
  spp_req_t    got;
  logic        rsp_due;
  logic [63:0] key_seen;
  int          nreq;
  int          error_cnt;
  int          comparisons;

  // low wins; the pull-up holds the wire high otherwise
  assign wire_lvl = (data_oe ? data_out : 1'b1) & pull_low_n;

  spp_link DUT (
    .core_clk               (core_clk),
    .resetn                 (resetn),
    .prog_link_clock_pin    (clk_pin),
    .prog_link_data_pin_in  (wire_lvl),
    .prog_link_data_pin_out (data_out),
    .prog_link_data_pin_oe  (data_oe),
    .req_valid              (req_valid),
    .req                    (req),
    .req_ready              (req_ready),
    .rsp_valid              (rsp_valid),
    .rsp_data               (rsp_data),
    .key_valid              (key_valid),
    .key_value              (key_value)
  );
  spp_prog_model PRG (
    .clk_pin    (clk_pin),
    .pull_low_n (pull_low_n),
    .wire_lvl   (wire_lvl)
  );

  initial
  begin
    core_clk = 1'b0;
    forever
      #4 core_clk = ~core_clk;
  end

  // system side: take requests, answer reads one cycle later
  always @(posedge core_clk)
  begin
    if (req_valid === 1'b1 && req_ready === 1'b1)
    begin
      got  <= req;
      nreq <= nreq + 1;
    end
    rsp_due <= req_valid === 1'b1 && req_ready === 1'b1 && !req.write;
    if (key_valid === 1'b1)
      key_seen <= key_value;
  end
  always @(posedge core_clk)
  begin
    #1;
    rsp_valid = rsp_due;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic set_ready(input logic v);
    @(posedge core_clk);
    #1;
    req_ready = v;
  endtask

  task automatic wait_req(input int n0);
    for (int i = 0; i < 40 && nreq == n0; i++)
      @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    PRG.send(op, 2'h0);
    PRG.send(d, 2'h0);
  endtask

  task automatic io_write(input logic [7:0] d, input logic hit);
    int n0;
    n0 = nreq;
    wr(8'h95, d);
    wait_req(n0);
    check(nreq - n0, hit);
    if (hit)
      check(got, {2'b11, 16'h0005, d});
  endtask

  task automatic rd(input logic [7:0] op, input int idle_exp,
                    input logic [7:0] d);
    int          idle;
    logic [11:0] f;
    int          n0;
    n0 = nreq;
    PRG.send(op, 2'h0);
    wait_req(n0);
    repeat (3) @(posedge core_clk);
    PRG.recv(1'b0, idle, f);
    check(idle, idle_exp);
    check(f, {2'b11, ^d, d, 1'b0});
  endtask

  task automatic t_guard;
    rd(8'h82, 130, 8'h80);
    wr(8'hc2, 8'h04);
    rd(8'h82, 6, 8'h04);
    rd(8'h83, 6, 8'h00);
    $display("test guard done");
  endtask

  task automatic t_stall;
    int n0;
    set_ready(1'b0);
    n0 = nreq;
    wr(8'h95, 8'ha5);
    wr(8'h95, 8'h5a);
    repeat (40) @(posedge core_clk);
    check(req, {2'b11, 16'h0005, 8'ha5});
    set_ready(1'b1);
    wait_req(n0);
    wait_req(n0 + 1);
    check(got, {2'b11, 16'h0005, 8'h5a});
    $display("test stall done");
  endtask

  task automatic t_errors;
    for (int k = 1; k < 5; k++)
    begin
      if (k == 3)
        PRG.brk();
      else
        PRG.send((k == 4) ? 8'h00 : 8'h95, k[1:0]);
      io_write(8'h3c, 1'b0);
      PRG.brk();
      io_write(8'h3c, 1'b1);
    end
    $display("test errors done");
  endtask

  task automatic t_collide;
    int          idle;
    logic [11:0] f;
    PRG.send(8'h82, 2'h0);
    repeat (40) @(posedge core_clk);
    PRG.recv(1'b1, idle, f);
    check(f, 12'hffe);
    check(data_oe, 1'b0);
    io_write(8'h11, 1'b0);
    PRG.brk();
    io_write(8'h11, 1'b1);
    $display("test collision done");
  endtask

  task automatic t_key;
    PRG.send(8'he0, 2'h0);
    for (int i = 1; i < 9; i++)
      PRG.send(8'(i * 17), 2'h0);
    repeat (40) @(posedge core_clk);
    check(key_seen, 64'h8877_6655_4433_2211);
    io_write(8'h22, 1'b1);
    $display("test key done");
  endtask

  task automatic t_data_read;
    int n0;
    wr(8'h68, 8'h34);
    wr(8'h69, 8'h12);
    rd(8'h24, 6, 8'hc3);
    check({got.write, got.io, got.addr}, {2'b00, 16'h1234});
    rd(8'h20, 6, 8'hc3);
    check({got.write, got.io, got.addr}, {2'b00, 16'h1235});
    rd(8'h15, 6, 8'hc3);
    check({got.write, got.io, got.addr}, {2'b01, 16'h0005});
    n0 = nreq;
    wr(8'h64, 8'h77);
    wait_req(n0);
    check(got, {2'b10, 16'h1235, 8'h77});
    n0 = nreq;
    wr(8'h60, 8'h78);
    wait_req(n0);
    check(got, {2'b10, 16'h1236, 8'h78});
    $display("test data read done");
  endtask

  initial
  begin
    resetn    = 1'b0;
    req_ready = 1'b1;
    rsp_valid = 1'b0;
    rsp_due   = 1'b0;
    rsp_data  = 8'hc3;
    key_seen  = 64'h0;
    repeat (2) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    repeat (4) @(posedge core_clk);
    t_guard;
    t_stall;
    t_errors;
    t_collide;
    t_key;
    t_data_read;
    close_out;
  end

  initial
  begin
    #600000;
    error_cnt++;
    close_out;
  end
endmodule
